// ==== rtl/mfc_micro_fetch_controller.sv ====
// Purpose: microprogrammed control and data path of a 16-bit emulated processor
// Assumes: control store and main memory are synchronous to ref_clk
// Notes:   control store data is combinational from ctrlStoreAddr (pipeline mode)
//
// Overview of operation
// - sixteen-bit words, four accumulators, two's complement arithmetic throughout
// - sixteen-level push/pop stack, all levels usable by the program
// - two-bit index picks base page, pc, ac2 or ac3 relative addressing
// - base page uses the eight-bit displacement unchanged, lowest 256 words
// - relative modes add signed displacement to pc or chosen accumulator
// - register entries 0-3 accumulators, 4 program counter, 5-7 scratch
// - address register loads from output bus; write data comes from it too
// - memory read data enters through a switch input port and directly into the instruction register, not the bus
// - instruction register holds opcode and index bits
// - field share: source, destination, control fields become ten-bit branch address
// - microword has six-bit switch field, four-bit sequencer field, memory bits
// - source decodes to one low output enable, destination to low clock accept
// - instruction and address register loads gated by destination decode
// - four-way next-address mux steered by two select outputs
// - mapper turns instruction register into routine start address
// - fetch one reads pc into output register, then steps sequentially
// - fetch two puts output on bus, loads address register, starts read
// - fetch three increments pc with carry while switch outputs zero
// - fetch four loads upper eight read bits into instruction register
// - fetch five loads scratch one with sign-extended low byte
// - fetch six branches via one so mapper output is next address
// - element ignores clock edge unless its clock accept is low
// - element drives output bus only while its output enable is low
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module mfc_micro_fetch_controller
	import mfc_pkg::*;
#(
	parameter int ADDR_W = APB_ADDR_W
) (
	// clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rst_b,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [ADDR_W-1:0]   paddr,
	input  wire logic [31:0]         pwdata,
	output logic                     pready,
	output logic      [31:0]         prdata,
	output logic                     pslverr,
	// control store
	output logic      [UADDR_W-1:0]  ctrlStoreAddr,
	input  wire logic [UWORD_W-1:0]  ctrlStoreData,
	// main memory
	output logic      [WORD_W-1:0]   memAddr,
	output logic      [WORD_W-1:0]   memWrData,
	output logic                     memRead,
	output logic                     memWrite,
	input  wire logic [WORD_W-1:0]   memRdData
);
	// microword fields of the executing word
	logic [UWORD_W-1:0] microWord_r;
	mfc_seq_cmd_t       seqCmd;
	mfc_dps_t           dpsOp;
	logic [MISC_W-1:0]  miscBits;
	logic [CODE_W-1:0]  srcCode;
	logic [CODE_W-1:0]  dstCode;
	logic [CTL_W-1:0]   ctlField;
	logic               fieldShareInhibit;
	logic [7:0]         busDriveEnable_n;
	logic [7:0]         clockAccept_n;
	// data path
	logic [WORD_W-1:0]  outBus;
	logic [WORD_W-1:0]  dpsOut;
	logic [WORD_W-1:0]  alrsOut;
	logic [WORD_W-1:0]  stackTop;
	logic [WORD_W-1:0]  effAddr;
	logic [WORD_W-1:0]  pcVal;
	logic [WORD_W-1:0]  ac2Val;
	logic [WORD_W-1:0]  ac3Val;
	logic [WORD_W-1:0]  temp1Val;
	logic [IR_W-1:0]    instrHold_r;
	logic [4:0]         stackDepth;
	logic               stackOverflow;
	logic               stackUnderflow;
	// sequencer
	mfc_seq_cmd_t       inSeq;
	logic               nextAddrSelectHi;
	logic               nextAddrSelectLo;
	logic [UADDR_W-1:0] branchAddressIn;
	logic [UADDR_W-1:0] mapperAddr;
	// software registers
	logic               run_r;
	logic [UADDR_W-1:0] mapBase_r;
	logic               ovfSticky_r;
	logic               udfSticky_r;
	logic               apbDone;
	logic               apbWrite;
	logic               addrHit;
	logic [31:0]        readMux;

	// one-hot active-low decode; code zero selects nothing
	function automatic logic [7:0] decodeLow(input logic [CODE_W-1:0] code, input logic inhibit);
		logic [7:0] oneHot;
		oneHot = 8'h01 << code;
		if (inhibit || code == '0) begin
			decodeLow = 8'hFF;
		end else begin
			decodeLow = ~oneHot;
		end
	endfunction

	// data path switch: port a is the bus loop, port k is memory
	function automatic logic [WORD_W-1:0] switchEval(input mfc_dps_t op,
			input logic [WORD_W-1:0] portA, input logic [WORD_W-1:0] portK);
		unique case (op)
			DPS_PASS_BUS: switchEval = portA;
			DPS_PASS_MEM: switchEval = portK;
			DPS_ZERO:     switchEval = '0;
			DPS_MEM_SEXT: switchEval = {{BYTE_W{portK[BYTE_W-1]}}, portK[BYTE_W-1:0]};
			DPS_MEM_HIGH: switchEval = {{BYTE_W{1'b0}}, portK[WORD_W-1:BYTE_W]};
			DPS_BUS_SWAP: switchEval = {portA[BYTE_W-1:0], portA[WORD_W-1:BYTE_W]};
			default:      switchEval = portA;
		endcase
	endfunction

	// field split of the executing microword
	assign seqCmd   = mfc_seq_cmd_t'(microWord_r[SEQ_LSB +: SEQ_W]);
	assign dpsOp    = mfc_dps_t'(microWord_r[DPS_LSB +: DPS_W]);
	assign miscBits = microWord_r[MISC_LSB +: MISC_W];
	assign srcCode  = microWord_r[SRC_LSB +: CODE_W];
	assign dstCode  = microWord_r[DST_LSB +: CODE_W];
	assign ctlField = microWord_r[CTL_LSB +: CTL_W];

	// shared fields carry a branch address on any branch, so decode is held off
	assign fieldShareInhibit = seqCmd != SEQ_STEP_SEQUENTIAL;
	assign busDriveEnable_n  = decodeLow(srcCode, fieldShareInhibit);
	assign clockAccept_n     = decodeLow(dstCode, fieldShareInhibit);

	// output bus: only the one enabled source drives; idle bus reads zero
	always_comb begin
		outBus = '0;
		if (!busDriveEnable_n[SRC_ALU_REGISTER_SLICE]) begin
			outBus = alrsOut;
		end else if (!busDriveEnable_n[SRC_STACK]) begin
			outBus = stackTop;
		end else if (!busDriveEnable_n[SRC_EA]) begin
			outBus = effAddr;
		end else if (!busDriveEnable_n[SRC_DPS]) begin
			outBus = dpsOut;
		end
	end

	// memory data enters the switch through port k; the instruction register takes it directly
	assign dpsOut = switchEval(dpsOp, outBus, memRdData);

	// effective address from index bits and scratch one displacement
	always_comb begin
		unique case (mfc_index_t'(instrHold_r[1:0]))
			IDX_BASE_PAGE: effAddr = {{BYTE_W{1'b0}}, temp1Val[BYTE_W-1:0]};
			IDX_PC_REL:    effAddr = pcVal + temp1Val;
			IDX_AC2_REL:   effAddr = ac2Val + temp1Val;
			IDX_AC3_REL:   effAddr = ac3Val + temp1Val;
		endcase
	end

	// arithmetic slice: read, load or add with carry into an entry
	mfc_register_slice #(
		.WIDTH(WORD_W),
		.NREGS(NUM_REGS)
	) alu_register_slice (
		.ref_clk      (ref_clk),
		.rst_b        (rst_b),
		.clockAccept_n(clockAccept_n[DST_ALU_REGISTER_SLICE]),
		.regSel       (ctlField[2:0]),
		.writeReg     (ctlField[CTL_WRITE_BIT]),
		.aluAdd       (miscBits[MISC_ALU_ADD]),
		.carryIn      (miscBits[MISC_CARRY_IN]),
		.dpsIn        (dpsOut),
		.outputReg    (alrsOut),
		.pcVal        (pcVal),
		.ac2Val       (ac2Val),
		.ac3Val       (ac3Val),
		.temp1Val     (temp1Val)
	);

	// push/pop stack shares the control field: write bit pushes, else pops
	mfc_push_stack #(
		.WIDTH(WORD_W),
		.DEPTH(STACK_DEPTH)
	) push_stack (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.push     (!clockAccept_n[DST_STACK] && ctlField[CTL_WRITE_BIT]),
		.pop      (!clockAccept_n[DST_STACK] && !ctlField[CTL_WRITE_BIT]),
		.pushData (outBus),
		.topOut   (stackTop),
		.depth    (stackDepth),
		.overflow (stackOverflow),
		.underflow(stackUnderflow)
	);

	// memory address register: a gated clock modelled as a load condition
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			memAddr <= '0;
		end else if (!clockAccept_n[DST_MAR]) begin
			memAddr <= outBus;
		end
	end

	// instruction register takes the upper byte of the read word
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			instrHold_r <= '0;
		end else if (!clockAccept_n[DST_IR]) begin
			instrHold_r <= memRdData[WORD_W-1:BYTE_W];
		end
	end

	// memory strobes; misc bits are never shared, so they act on branches too
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			memRead   <= 1'b0;
			memWrite  <= 1'b0;
			memWrData <= '0;
		end else begin
			memRead  <= miscBits[MISC_MEM_READ];
			memWrite <= miscBits[MISC_MEM_WRITE];
			if (miscBits[MISC_MEM_WRITE]) memWrData <= outBus;
		end
	end

	// next-address select from the word arriving from the control store
	assign inSeq = mfc_seq_cmd_t'(ctrlStoreData[SEQ_LSB +: SEQ_W]);
	always_comb begin
		unique case (inSeq)
			SEQ_STEP_SEQUENTIAL: {nextAddrSelectHi, nextAddrSelectLo} = 2'b00;
			SEQ_BRANCH_VIA_ZERO: {nextAddrSelectHi, nextAddrSelectLo} = 2'b01;
			SEQ_BRANCH_VIA_ONE:  {nextAddrSelectHi, nextAddrSelectLo} = 2'b10;
			SEQ_BRANCH_VIA_TWO:  {nextAddrSelectHi, nextAddrSelectLo} = 2'b11;
			default:             {nextAddrSelectHi, nextAddrSelectLo} = 2'b00;
		endcase
	end

	// mapper: four control words reserved per opcode above a base
	assign mapperAddr = mapBase_r + {2'b00, instrHold_r[IR_W-1:2], 2'b00};

	// four-way branch address multiplexer
	always_comb begin
		unique case ({nextAddrSelectHi, nextAddrSelectLo})
			2'b00: branchAddressIn = ctrlStoreAddr + UADDR_W'(1);
			2'b01: branchAddressIn = ctrlStoreData[UADDR_W-1:0];
			2'b10: branchAddressIn = mapperAddr;
			2'b11: branchAddressIn = FETCH_ENTRY;
		endcase
	end

	// pipeline: address and word advance together; stopped means parked at fetch
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrlStoreAddr <= FETCH_ENTRY;
			microWord_r   <= NOP_WORD;
		end else if (!run_r) begin
			ctrlStoreAddr <= FETCH_ENTRY;
			microWord_r   <= NOP_WORD;
		end else begin
			ctrlStoreAddr <= branchAddressIn;
			microWord_r   <= ctrlStoreData;
		end
	end

	// apb: one wait state so read data can come from a flop
	assign apbDone  = psel && penable && pready;
	assign apbWrite = apbDone && pwrite;
	always_comb begin
		addrHit = 1'b1;
		readMux = '0;
		unique case (paddr)
			OFS_CTRL:     readMux[CTRL_RUN_BIT] = run_r;
			OFS_MAP_BASE: readMux[UADDR_W-1:0] = mapBase_r;
			OFS_STATUS: begin
				readMux[UADDR_W-1:0]            = ctrlStoreAddr;
				readMux[STAT_DEPTH_LSB +: 5]    = stackDepth;
				readMux[STAT_OVF_BIT]           = ovfSticky_r;
				readMux[STAT_UDF_BIT]           = udfSticky_r;
				readMux[STAT_INH_BIT]           = fieldShareInhibit;
			end
			OFS_IR_MAR: begin
				readMux[IR_W-1:0]               = instrHold_r;
				readMux[IRMAR_MAR_LSB +: WORD_W] = memAddr;
			end
			OFS_ALU_OUT:  readMux[WORD_W-1:0] = alrsOut;
			default:      addrHit = 1'b0;
		endcase
	end

	// handshake and read data capture
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !addrHit;
			if (psel && penable && !pready) prdata <= pwrite ? 32'h00000000 : readMux;
		end
	end

	// control registers take effect at the completing edge only
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			run_r     <= 1'b0;
			mapBase_r <= MAP_BASE_RESET;
		end else if (apbWrite && paddr == OFS_CTRL) begin
			run_r <= pwdata[CTRL_RUN_BIT];
		end else if (apbWrite && paddr == OFS_MAP_BASE) begin
			mapBase_r <= pwdata[UADDR_W-1:0];
		end
	end

	// sticky stack errors: a new event beats a write-one clear
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ovfSticky_r <= 1'b0;
			udfSticky_r <= 1'b0;
		end else begin
			if (stackOverflow) begin
				ovfSticky_r <= 1'b1;
			end else if (apbWrite && paddr == OFS_STATUS && pwdata[STAT_OVF_BIT]) begin
				ovfSticky_r <= 1'b0;
			end
			if (stackUnderflow) begin
				udfSticky_r <= 1'b1;
			end else if (apbWrite && paddr == OFS_STATUS && pwdata[STAT_UDF_BIT]) begin
				udfSticky_r <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ==== rtl/mfc_pkg.sv ====
// Purpose: shared constants and types for the micro fetch controller
// Assumes: 16-bit data path, 10-bit control store address, 24-bit microword
// Notes:   microword layout and register offsets live here only
`default_nettype none
package mfc_pkg;
	// data path geometry
	localparam int WORD_W      = 16;
	localparam int BYTE_W      = 8;
	localparam int UADDR_W     = 10;
	localparam int UWORD_W     = 24;
	localparam int IR_W        = 8;
	localparam int NUM_REGS    = 8;
	localparam int STACK_DEPTH = 16;
	localparam int APB_ADDR_W  = 8;
	// microword field positions
	localparam int SEQ_LSB  = 20;
	localparam int SEQ_W    = 4;
	localparam int DPS_LSB  = 14;
	localparam int DPS_W    = 6;
	localparam int MISC_LSB = 10;
	localparam int MISC_W   = 4;
	localparam int SRC_LSB  = 7;
	localparam int DST_LSB  = 4;
	localparam int CTL_LSB  = 0;
	localparam int CODE_W   = 3;
	localparam int CTL_W    = 4;
	localparam int CTL_WRITE_BIT = 3;
	// miscellaneous field bits
	localparam int MISC_MEM_READ  = 0;
	localparam int MISC_MEM_WRITE = 1;
	localparam int MISC_ALU_ADD   = 2;
	localparam int MISC_CARRY_IN  = 3;
	// register file allocation
	localparam logic [2:0] REG_AC2   = 3'h2;
	localparam logic [2:0] REG_AC3   = 3'h3;
	localparam logic [2:0] REG_PC    = 3'h4;
	localparam logic [2:0] REG_TEMP1 = 3'h5;
	// sequencer and reset values
	localparam logic [UADDR_W-1:0] FETCH_ENTRY    = 10'h000;
	localparam logic [UWORD_W-1:0] NOP_WORD       = 24'h000000;
	localparam logic [UADDR_W-1:0] MAP_BASE_RESET = 10'h100;
	// APB register byte offsets
	localparam logic [APB_ADDR_W-1:0] OFS_CTRL     = 8'h00;
	localparam logic [APB_ADDR_W-1:0] OFS_MAP_BASE = 8'h04;
	localparam logic [APB_ADDR_W-1:0] OFS_STATUS   = 8'h08;
	localparam logic [APB_ADDR_W-1:0] OFS_IR_MAR   = 8'h0C;
	localparam logic [APB_ADDR_W-1:0] OFS_ALU_OUT  = 8'h10;
	// register field positions
	localparam int CTRL_RUN_BIT   = 0;
	localparam int STAT_DEPTH_LSB = 10;
	localparam int STAT_OVF_BIT   = 16;
	localparam int STAT_UDF_BIT   = 17;
	localparam int STAT_INH_BIT   = 18;
	localparam int IRMAR_MAR_LSB  = 16;
	// enumerations
	typedef enum logic [3:0] {
		SEQ_STEP_SEQUENTIAL = 4'h0,
		SEQ_BRANCH_VIA_ZERO = 4'h1,
		SEQ_BRANCH_VIA_ONE  = 4'h3,
		SEQ_BRANCH_VIA_TWO  = 4'h2
	} mfc_seq_cmd_t;
	typedef enum logic [2:0] {
		SRC_NONE = 3'h0, SRC_ALU_REGISTER_SLICE = 3'h1, SRC_STACK = 3'h2, SRC_EA = 3'h3, SRC_DPS = 3'h4
	} mfc_src_t;
	typedef enum logic [2:0] {
		DST_NONE = 3'h0, DST_ALU_REGISTER_SLICE = 3'h1, DST_MAR = 3'h2, DST_IR = 3'h3, DST_STACK = 3'h4
	} mfc_dst_t;
	typedef enum logic [5:0] {
		DPS_PASS_BUS = 6'h00, DPS_PASS_MEM = 6'h01, DPS_ZERO = 6'h02,
		DPS_MEM_SEXT = 6'h03, DPS_MEM_HIGH = 6'h04, DPS_BUS_SWAP = 6'h05
	} mfc_dps_t;
	typedef enum logic [1:0] {
		IDX_BASE_PAGE = 2'h0, IDX_PC_REL = 2'h1, IDX_AC2_REL = 2'h2, IDX_AC3_REL = 2'h3
	} mfc_index_t;
endpackage
`default_nettype wire

// ==== rtl/mfc_register_slice.sv ====
// Purpose: eight-entry register file with adder and registered output
// Assumes: one write port, async read ports for address arithmetic
// Notes:   output register only moves when the clock accept is low
`timescale 1ns/10ps
`default_nettype none
module mfc_register_slice
	import mfc_pkg::*;
#(
	parameter int WIDTH = WORD_W,
	parameter int NREGS = NUM_REGS
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst_b,
	// control
	input  wire logic             clockAccept_n,
	input  wire logic [2:0]       regSel,
	input  wire logic             writeReg,
	input  wire logic             aluAdd,
	input  wire logic             carryIn,
	input  wire logic [WIDTH-1:0] dpsIn,
	// results
	output logic      [WIDTH-1:0] outputReg,
	output logic      [WIDTH-1:0] pcVal,
	output logic      [WIDTH-1:0] ac2Val,
	output logic      [WIDTH-1:0] ac3Val,
	output logic      [WIDTH-1:0] temp1Val
);
	logic [WIDTH-1:0] regFile [NREGS];
	logic [WIDTH-1:0] result;

	// two's complement add wraps modulo the word width
	assign result   = aluAdd ? regFile[regSel] + dpsIn + {{(WIDTH-1){1'b0}}, carryIn} : dpsIn;
	assign pcVal    = regFile[REG_PC];
	assign ac2Val   = regFile[REG_AC2];
	assign ac3Val   = regFile[REG_AC3];
	assign temp1Val = regFile[REG_TEMP1];

	// register file write, edge ignored unless accepted
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NREGS; i++) regFile[i] <= '0;
		end else if (!clockAccept_n && writeReg) begin
			regFile[regSel] <= result;
		end
	end

	// output register holds a read or the written result
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			outputReg <= '0;
		end else if (!clockAccept_n) begin
			outputReg <= writeReg ? result : regFile[regSel];
		end
	end
endmodule
`default_nettype wire

// ==== rtl/mfc_push_stack.sv ====
// Purpose: push/pop word stack with registered top output
// Assumes: push and pop never asserted together
// Notes:   full push and empty pop are dropped and reported by a pulse
`timescale 1ns/10ps
`default_nettype none
module mfc_push_stack
	import mfc_pkg::*;
#(
	parameter int WIDTH = WORD_W,
	parameter int DEPTH = STACK_DEPTH,
	parameter int PTR_W = $clog2(DEPTH) + 1
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst_b,
	// requests
	input  wire logic             push,
	input  wire logic             pop,
	input  wire logic [WIDTH-1:0] pushData,
	// results
	output logic      [WIDTH-1:0] topOut,
	output logic      [PTR_W-1:0] depth,
	output logic                  overflow,
	output logic                  underflow
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic             isFull;
	logic             isEmpty;

	assign isFull  = depth == PTR_W'(DEPTH);
	assign isEmpty = depth == '0;

	// storage: every one of the levels is usable
	always_ff @(posedge ref_clk) begin
		if (push && !isFull) mem[depth[PTR_W-2:0]] <= pushData;
	end

	// pointer, popped word and error pulses
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			depth     <= '0;
			topOut    <= '0;
			overflow  <= 1'b0;
			underflow <= 1'b0;
		end else begin
			overflow  <= push && isFull;
			underflow <= pop && isEmpty;
			if (push && !isFull) begin
				depth <= depth + PTR_W'(1);
			end else if (pop && !isEmpty) begin
				topOut <= mem[depth[PTR_W-2:0] - (PTR_W-1)'(1)]; // index width matches the storage depth
				depth  <= depth - PTR_W'(1);
			end
		end
	end
endmodule
`default_nettype wire

// ==== verif/mfc_mem_model.sv ====
// Purpose: control store and main memory seen by the controller
// Assumes: store answers combinationally, read data holds until the next read
// Notes:   region 0x3xx branches to itself so a finished fetch can be frozen
`timescale 1ns/10ps
`default_nettype none
module mfc_mem_model
	import mfc_pkg::*;
(
	// clock
	input  wire logic               ref_clk,
	// control store
	input  wire logic [UADDR_W-1:0] ctrlStoreAddr,
	output logic      [UWORD_W-1:0] ctrlStoreData,
	// main memory
	input  wire logic [WORD_W-1:0]  memAddr,
	input  wire logic               memRead,
	output logic      [WORD_W-1:0]  memRdData
);
	logic [WORD_W-1:0] heldAddr;
	logic [WORD_W-1:0] rdAddr;
	// fetch routine, then return to entry or spin in place
	always_comb begin
		case (ctrlStoreAddr)
			10'h000: ctrlStoreData = 24'h000014;
			10'h001: ctrlStoreData = 24'h0004A0;
			10'h002: ctrlStoreData = 24'h00B01C;
			10'h003: ctrlStoreData = 24'h000030;
			10'h004: ctrlStoreData = 24'h00C01D;
			10'h005: ctrlStoreData = 24'h300000;
			default: ctrlStoreData = (ctrlStoreAddr[9:8] == 2'h3) ? {4'h1, 10'h000, ctrlStoreAddr} : 24'h200000;
		endcase
	end
	// address kept from the strobe, so data stays put through steps three to five
	always_ff @(posedge ref_clk) begin
		if (memRead) begin
			heldAddr <= memAddr;
		end
	end
	assign rdAddr = memRead ? memAddr : heldAddr;
	assign memRdData = {rdAddr[7:0] ^ 8'hA5, rdAddr[7:0] ^ 8'h5A};
endmodule
`default_nettype wire

// ==== verif/mfc_asserts.sv ====
// Purpose: port-level checks of sequencing, the memory read strobe and bus answers
// Assumes: run state is tracked by snooping completed writes to the control register
// Notes:   strobe timing allows one or two cycles after the fetched word, address load timing exactly two
`timescale 1ns/10ps
`default_nettype none
module mfc_asserts
	import mfc_pkg::*;
#(
	parameter int ADDR_W = APB_ADDR_W
) (
	// clock and reset
	input  wire logic               ref_clk,
	input  wire logic               rst_b,
	// apb
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [ADDR_W-1:0]  paddr,
	input  wire logic [31:0]        pwdata,
	input  wire logic               pready,
	input  wire logic               pslverr,
	// store and memory
	input  wire logic [UADDR_W-1:0] ctrlStoreAddr,
	input  wire logic [UWORD_W-1:0] ctrlStoreData,
	input  wire logic [WORD_W-1:0]  memAddr,
	input  wire logic               memRead
);
	logic       runS;
	logic [3:0] seqF;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	assign seqF = ctrlStoreData[SEQ_LSB+:SEQ_W];
	// shadow of the run bit, taken at the completing edge
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			runS <= 1'b0;
		end else if (psel && penable && pready && pwrite && paddr == OFS_CTRL) begin
			runS <= pwdata[CTRL_RUN_BIT];
		end
	end
	AST_STEP: assert property (runS && seqF == 4'h0 |=> ctrlStoreAddr == $past(ctrlStoreAddr) + 10'h001)
		else $error("sequential step went elsewhere");
	AST_BRANCH: assert property (runS && seqF == 4'h1 |=> ctrlStoreAddr == $past(ctrlStoreData[9:0]))
		else $error("branch field not taken");
	AST_ENTRY: assert property (runS && seqF == 4'h2 |=> ctrlStoreAddr == FETCH_ENTRY)
		else $error("return to fetch entry missed");
	AST_MAP_ALIGN: assert property (runS && seqF == 4'h3 |=> ctrlStoreAddr[1:0] == 2'h0)
		else $error("mapped address not word aligned");
	AST_PARK: assert property (!runS |=> ctrlStoreAddr == FETCH_ENTRY)
		else $error("stopped sequencer left entry");
	AST_READ: assert property (runS && ctrlStoreData[MISC_LSB+MISC_MEM_READ] |-> ##[1:2] memRead)
		else $error("read strobe missing");
	AST_MAR: assert property (!$stable(memAddr) |-> $past(ctrlStoreData[6:4], 2) == DST_MAR)
		else $error("address register moved without a load");
	AST_READY: assert property (psel && penable && !pready |=> pready ##1 !pready)
		else $error("bus answer not a single cycle after access");
	AST_ERR: assert property (pready && paddr > OFS_ALU_OUT |-> pslverr)
		else $error("unmapped access not refused");
endmodule
bind mfc_micro_fetch_controller mfc_asserts #(.ADDR_W(ADDR_W)) i_mfc_asserts (.ref_clk(ref_clk), .rst_b(rst_b),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .ctrlStoreAddr(ctrlStoreAddr), .ctrlStoreData(ctrlStoreData), .memAddr(memAddr),
	.memRead(memRead));
`default_nettype wire

// ==== verif/tb_top.sv ====
// Purpose: register and fetch checks of the micro fetch controller
// Assumes: program counter and registers clear on reset
// Notes:   a map base change parks the machine in a self loop before the final reads
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import mfc_pkg::*;
;
	logic        ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, memRead, memWrite, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [9:0]  ctrlStoreAddr, prevCsa;
	logic [23:0] ctrlStoreData;
	logic [15:0] memAddr, memWrData, memRdData, lastA;
	logic [7:0]  ofs [5];
	logic [31:0] rv [5];
	int          errors, comparisons, fetches, n;
	mfc_micro_fetch_controller i_mfc_micro_fetch_controller (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .ctrlStoreAddr(ctrlStoreAddr), .ctrlStoreData(ctrlStoreData), .memAddr(memAddr),
		.memWrData(memWrData), .memRead(memRead), .memWrite(memWrite), .memRdData(memRdData));
	mfc_mem_model i_mfc_mem_model (.ref_clk(ref_clk), .ctrlStoreAddr(ctrlStoreAddr), .ctrlStoreData(ctrlStoreData),
		.memAddr(memAddr), .memRead(memRead), .memRdData(memRdData));
	always #4 ref_clk = ~ref_clk;
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_of_test();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// one transfer; waits for ready under a bound
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			errors++;
			end_of_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// read addresses follow the counter; the first mapped address follows the fetched word
	always @(posedge ref_clk) begin
		if (rst_b === 1'b1 && memRead === 1'b1) begin
			chk("read address", {16'h0, memAddr}, 32'(fetches));
			chk("no memory write", {15'h0, memWrite, memWrData}, 32'h0);
			fetches++;
			lastA = memAddr;
		end
		if (ctrlStoreAddr[9] === 1'b1 && prevCsa === 10'h005) begin
			chk("mapped address", {24'h0, ctrlStoreAddr[7:0]}, {24'h0, (lastA[7:0] ^ 8'hA5) & 8'hFC});
		end
		prevCsa = ctrlStoreAddr;
	end
	initial begin
		ref_clk = 1'b0;
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		errors = 0;
		comparisons = 0;
		fetches = 0;
		lastA = 16'h0;
		prevCsa = 10'h0;
		ofs = '{OFS_CTRL, OFS_MAP_BASE, OFS_STATUS, OFS_IR_MAR, OFS_ALU_OUT};
		rv = '{32'h0, {22'h0, MAP_BASE_RESET}, 32'h0, 32'h0, 32'h0};
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		// reset values and a refused address
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, ofs[i], 32'h0);
			chk("reset value", rd, rv[i]);
		end
		apb(1'b1, 8'h40, 32'hFFFFFFFF);
		chk("unmapped error", {31'h0, err}, 32'h1);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped data", rd, 32'h0);
		// run fetches through the 0x2xx return region
		apb(1'b1, OFS_MAP_BASE, 32'h200);
		apb(1'b0, OFS_MAP_BASE, 32'h0);
		chk("map base", rd, 32'h200);
		apb(1'b1, OFS_CTRL, 32'h1);
		repeat (60) @(posedge ref_clk);
		apb(1'b1, OFS_MAP_BASE, 32'h300);
		n = 0;
		while (ctrlStoreAddr[9:8] !== 2'h3 && n < 100) begin
			@(posedge ref_clk);
			n++;
		end
		chk("self loop reached", 32'(n < 100), 32'h1);
		if (n >= 100) end_of_test();
		apb(1'b1, OFS_CTRL, 32'h0);
		apb(1'b0, OFS_IR_MAR, 32'h0);
		chk("address register", {16'h0, rd[31:16]}, {16'h0, lastA});
		chk("instruction register", {24'h0, rd[7:0]}, {24'h0, lastA[7:0] ^ 8'hA5});
		chk("several fetches", 32'(fetches > 3), 32'h1);
		// last fetch left the sign-extended low byte in the slice output register
		apb(1'b0, OFS_ALU_OUT, 32'h0);
		chk("scratch one", rd, {16'h0, {8{lastA[7]}}, lastA[7:0] ^ 8'h5A});
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("parked address", {22'h0, rd[9:0]}, 32'h0);
		end_of_test();
	end
endmodule
`default_nettype wire
